// ==== ect_core.sv ====
`timescale 1ns/10ps
// Functional notes
// - Readout-done and profile triggers clear counter
// - Line three or four clears on edge
// - Timer or counter done event clears counter
// - Clear edge: up, down or either
// - Count equals terminal value gives done event
// - Live count is always readable
// - Count before clear is captured
// - Clear command zeroes; counting resumes immediately
// - Timer selector; only timer one exists
// - Timer off or active; configure while off
// - Timer status: idle, waiting, running, done
// - Done at duration, running while below
// - Capture, exposure, readout, profile events start timer
// - Line three or four edge starts timer
// - Timer done, counter done, sync start timer
// - Source Off: start only on clear command
// - Start edge: up, down or either
// - Timer runs exactly length microseconds, one for length zero
// - Elapsed microseconds readable
// - Timer clear command zeroes elapsed value
// - Event-cleared counter waits for next start event
module ect_core
    import ect_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_capture_session_begin,
    input wire logic i_capture_session_done,
    input wire logic i_exposure_begin_event,
    input wire logic i_exposure_done_event,
    input wire logic i_sensor_readout_begin,
    input wire logic i_sensor_readout_done,
    input wire logic i_profile_trigger_event,
    input wire logic i_accepted_profile_trigger,
    input wire logic i_rejected_profile_trigger,
    input wire logic i_multi_unit_sync_signal,
    input wire logic i_io_line_three,
    input wire logic i_io_line_four,
    input wire logic i_count_step,
    input wire logic i_count_begin_event,
    input wire logic [3:0] i_count_clear_select,
    input wire logic [1:0] i_count_clear_edge_select,
    input wire logic [ECT_CNT_W-1:0] i_count_terminal_value,
    input wire logic i_count_clear_command,
    input wire logic i_tmr_instance_select,
    input wire logic i_tmr_enable_setting,
    input wire logic [3:0] i_tmr_begin_select,
    input wire logic [1:0] i_tmr_begin_edge_select,
    input wire logic [ECT_TMR_W-1:0] i_tmr_length_us,
    input wire logic i_tmr_clear_command,
    output logic [ECT_CNT_W-1:0] o_count_live_value,
    output logic [ECT_CNT_W-1:0] o_count_captured_at_clear,
    output logic o_count_terminal_event,
    output logic o_count_running,
    output logic [1:0] o_tmr_state_readback,
    output logic [ECT_TMR_W-1:0] o_tmr_elapsed_us,
    output logic o_first_tmr_done_event
);

    ////////////////////////////////////////////////////////////////////////
    // I/O line synchronisers

    logic [1:0] line_pins;
    logic [1:0] line_rise;
    logic [1:0] line_fall;

    assign line_pins = {i_io_line_four, i_io_line_three};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_line
            ect_edge_sync u_sync (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .i_pin(line_pins[gi]),
                .o_rise(line_rise[gi]),
                .o_fall(line_fall[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // One microsecond prescaler

    logic [ECT_PRE_W-1:0] pre_r;
    logic us_tick;
    logic tmr_start;

    assign us_tick = (pre_r == ECT_PRE_W'(ECT_TICK_CYC - 1));

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pre_r <= '0;
        end else if (tmr_start) begin
            // Restarting with the timer keeps its duration exact, not up to a tick short
            pre_r <= '0;
        end else begin
            pre_r <= us_tick ? '0 : pre_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter clear selection

    logic [ECT_CNT_W-1:0] cnt_r;
    logic [ECT_CNT_W-1:0] cnt_nxt;
    logic [ECT_CNT_W-1:0] cap_r;
    logic cnt_run_r;
    logic cnt_run_nxt;
    logic cnt_end_r;
    logic tmr_end_r;
    logic clr_edge3;
    logic clr_edge4;
    logic clr_event;
    logic clr_any;
    logic cnt_hit;

    // Qualify a line by the chosen edge
    // Code three qualifies no edge, so that selection stays quiet
    function automatic logic edge_pick(input logic [1:0] sel, input logic rise, input logic fall);
        logic r;
        r = 1'b0;
        if (sel == ECT_EDGE_UP) begin
            r = rise;
        end else if (sel == ECT_EDGE_DOWN) begin
            r = fall;
        end else if (sel == ECT_EDGE_EITHER) begin
            r = rise | fall;
        end
        return r;
    endfunction

    assign clr_edge3 = edge_pick(i_count_clear_edge_select, line_rise[0], line_fall[0]);
    assign clr_edge4 = edge_pick(i_count_clear_edge_select, line_rise[1], line_fall[1]);

    always_comb begin
        clr_event = 1'b0;
        case (i_count_clear_select)
            ECT_CLR_CAP_BEGIN: clr_event = i_capture_session_begin;
            ECT_CLR_CAP_DONE: clr_event = i_capture_session_done;
            ECT_CLR_EXP_BEGIN: clr_event = i_exposure_begin_event;
            ECT_CLR_EXP_DONE: clr_event = i_exposure_done_event;
            ECT_CLR_RD_BEGIN: clr_event = i_sensor_readout_begin;
            ECT_CLR_RD_DONE: clr_event = i_sensor_readout_done;
            ECT_CLR_PROF: clr_event = i_profile_trigger_event;
            ECT_CLR_PROF_OK: clr_event = i_accepted_profile_trigger;
            ECT_CLR_PROF_BAD: clr_event = i_rejected_profile_trigger;
            ECT_CLR_IO_LINE_THREE: clr_event = clr_edge3;
            ECT_CLR_IO_LINE_FOUR: clr_event = clr_edge4;
            ECT_CLR_TMR1: clr_event = tmr_end_r;
            ECT_CLR_CNT1: clr_event = cnt_end_r;
            default: clr_event = 1'b0;
        endcase
    end

    assign clr_any = clr_event | i_count_clear_command;
    // Only one equality pulse per arrival; stepping past the value does not repeat it
    assign cnt_hit = cnt_run_r & i_count_step & (cnt_r + 1'b1 == i_count_terminal_value);

    ////////////////////////////////////////////////////////////////////////
    // Counter datapath

    // A step in the clear cycle is dropped so the zero is exact
    always_comb begin
        cnt_nxt = cnt_r;
        cnt_run_nxt = cnt_run_r;
        if (i_count_clear_command) begin
            cnt_nxt = ECT_CNT_RST;
            cnt_run_nxt = 1'b1;
        end else if (clr_event) begin
            cnt_nxt = ECT_CNT_RST;
            cnt_run_nxt = 1'b0;
        end else begin
            if (i_count_begin_event) begin
                cnt_run_nxt = 1'b1;
            end
            if (cnt_run_r & i_count_step) begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    // A clear in the step cycle also suppresses the terminal pulse
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= ECT_CNT_RST;
            cap_r <= ECT_CNT_RST;
            cnt_run_r <= 1'b0;
            cnt_end_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            cnt_run_r <= cnt_run_nxt;
            cnt_end_r <= cnt_hit & ~clr_any;
            if (clr_any) begin
                cap_r <= cnt_r;
            end
        end
    end

    assign o_count_live_value = cnt_r;
    assign o_count_captured_at_clear = cap_r;
    assign o_count_terminal_event = cnt_end_r;
    assign o_count_running = cnt_run_r;

    ////////////////////////////////////////////////////////////////////////
    // Timer start selection

    typedef enum logic [1:0] {
        ECT_T_IDLE,
        ECT_T_WAIT,
        ECT_T_RUN,
        ECT_T_DONE
    } ect_tmr_state_t;

    ect_tmr_state_t tst_r;
    ect_tmr_state_t tst_nxt;
    logic [ECT_TMR_W-1:0] tel_r;
    logic [ECT_TMR_W-1:0] tel_nxt;
    logic tmr_sel_ok;
    logic tmr_on;
    logic beg_edge3;
    logic beg_edge4;
    logic beg_event;
    logic tmr_clear;
    logic tmr_reach;
    logic tmr_end_nxt;
    logic tmr_armed;

    // Only instance zero exists; other selections block only the timer clear command
    assign tmr_sel_ok = (i_tmr_instance_select == 1'b0);
    assign tmr_on = i_tmr_enable_setting;
    assign tmr_clear = i_tmr_clear_command & tmr_sel_ok;

    assign beg_edge3 = edge_pick(i_tmr_begin_edge_select, line_rise[0], line_fall[0]);
    assign beg_edge4 = edge_pick(i_tmr_begin_edge_select, line_rise[1], line_fall[1]);

    always_comb begin
        beg_event = 1'b0;
        case (i_tmr_begin_select)
            ECT_BEG_CAP_BEGIN: beg_event = i_capture_session_begin;
            ECT_BEG_CAP_DONE: beg_event = i_capture_session_done;
            ECT_BEG_EXP_BEGIN: beg_event = i_exposure_begin_event;
            ECT_BEG_EXP_DONE: beg_event = i_exposure_done_event;
            ECT_BEG_RD_BEGIN: beg_event = i_sensor_readout_begin;
            ECT_BEG_RD_DONE: beg_event = i_sensor_readout_done;
            ECT_BEG_PROF: beg_event = i_profile_trigger_event;
            ECT_BEG_PROF_OK: beg_event = i_accepted_profile_trigger;
            ECT_BEG_SYNC: beg_event = i_multi_unit_sync_signal;
            ECT_BEG_IO_LINE_THREE: beg_event = beg_edge3;
            ECT_BEG_IO_LINE_FOUR: beg_event = beg_edge4;
            ECT_BEG_TMR1: beg_event = tmr_end_r;
            ECT_BEG_CNT1: beg_event = cnt_end_r;
            default: beg_event = 1'b0;
        endcase
    end

    // Length zero completes on the first tick rather than never
    assign tmr_reach = (tel_r + 1'b1 >= i_tmr_length_us);

    ////////////////////////////////////////////////////////////////////////
    // Timer start detection

    // A trigger counts only while waiting or done; a running timer ignores it
    assign tmr_armed = (tst_r == ECT_T_WAIT) || (tst_r == ECT_T_DONE);
    assign tmr_start = tmr_on & (tmr_clear | (beg_event & tmr_armed));

    ////////////////////////////////////////////////////////////////////////
    // Timer state machine

    always_comb begin
        tst_nxt = tst_r;
        tel_nxt = tel_r;
        tmr_end_nxt = 1'b0;
        if (!tmr_on) begin
            tst_nxt = ECT_T_IDLE;
            if (tmr_clear) begin
                tel_nxt = ECT_TMR_RST;
            end
        end else if (tmr_clear) begin
            tel_nxt = ECT_TMR_RST;
            tst_nxt = ECT_T_RUN;
        end else begin
            unique case (tst_r)
                ECT_T_IDLE: begin
                    tst_nxt = ECT_T_WAIT;
                end
                ECT_T_WAIT, ECT_T_DONE: begin
                    if (beg_event) begin
                        tel_nxt = ECT_TMR_RST;
                        tst_nxt = ECT_T_RUN;
                    end
                end
                ECT_T_RUN: begin
                    if (us_tick) begin
                        tel_nxt = tel_r + 1'b1;
                        if (tmr_reach) begin
                            tst_nxt = ECT_T_DONE;
                            tmr_end_nxt = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tst_r <= ECT_T_IDLE;
            tel_r <= ECT_TMR_RST;
            tmr_end_r <= 1'b0;
        end else begin
            tst_r <= tst_nxt;
            tel_r <= tel_nxt;
            tmr_end_r <= tmr_end_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readback

    logic [1:0] st_code;

    always_comb begin
        st_code = ECT_ST_IDLE;
        unique case (tst_r)
            ECT_T_IDLE: st_code = ECT_ST_IDLE;
            ECT_T_WAIT: st_code = ECT_ST_WAIT;
            ECT_T_RUN: st_code = ECT_ST_RUN;
            ECT_T_DONE: st_code = ECT_ST_DONE;
        endcase
    end

    // Decoded straight from the state register, so it moves with the state
    assign o_tmr_state_readback = st_code;
    assign o_tmr_elapsed_us = tel_r;
    assign o_first_tmr_done_event = tmr_end_r;

endmodule

// ==== ect_pkg.sv ====
package ect_pkg;

    // Widths of the count and timer datapaths
    localparam int ECT_CNT_W = 32;
    localparam int ECT_TMR_W = 32;

    // Tick prescaler: 1 us at 100 MHz
    localparam int ECT_CLK_MHZ = 100;
    localparam int ECT_TICK_US = 1;
    localparam int ECT_TICK_CYC = ECT_CLK_MHZ * ECT_TICK_US;
    localparam int ECT_PRE_W = 8;

    // Reset values
    localparam logic [ECT_CNT_W-1:0] ECT_CNT_RST = 32'h0000_0000;
    localparam logic [ECT_TMR_W-1:0] ECT_TMR_RST = 32'h0000_0000;

    // Edge qualification encoding
    typedef enum logic [1:0] {
        ECT_EDGE_UP = 2'h0,
        ECT_EDGE_DOWN = 2'h1,
        ECT_EDGE_EITHER = 2'h2
    } ect_edge_t;

    // Counter clear source encoding; off means command only
    typedef enum logic [3:0] {
        ECT_CLR_OFF = 4'h0,
        ECT_CLR_CAP_BEGIN = 4'h1,
        ECT_CLR_CAP_DONE = 4'h2,
        ECT_CLR_EXP_BEGIN = 4'h3,
        ECT_CLR_EXP_DONE = 4'h4,
        ECT_CLR_RD_BEGIN = 4'h5,
        ECT_CLR_RD_DONE = 4'h6,
        ECT_CLR_PROF = 4'h7,
        ECT_CLR_PROF_OK = 4'h8,
        ECT_CLR_PROF_BAD = 4'h9,
        ECT_CLR_IO_LINE_THREE = 4'ha,
        ECT_CLR_IO_LINE_FOUR = 4'hb,
        ECT_CLR_TMR1 = 4'hc,
        ECT_CLR_CNT1 = 4'hd
    } ect_clr_src_t;

    // Timer start source encoding; off means command only
    typedef enum logic [3:0] {
        ECT_BEG_OFF = 4'h0,
        ECT_BEG_CAP_BEGIN = 4'h1,
        ECT_BEG_CAP_DONE = 4'h2,
        ECT_BEG_EXP_BEGIN = 4'h3,
        ECT_BEG_EXP_DONE = 4'h4,
        ECT_BEG_RD_BEGIN = 4'h5,
        ECT_BEG_RD_DONE = 4'h6,
        ECT_BEG_PROF = 4'h7,
        ECT_BEG_PROF_OK = 4'h8,
        ECT_BEG_SYNC = 4'h9,
        ECT_BEG_IO_LINE_THREE = 4'ha,
        ECT_BEG_IO_LINE_FOUR = 4'hb,
        ECT_BEG_TMR1 = 4'hc,
        ECT_BEG_CNT1 = 4'hd
    } ect_beg_src_t;

    // Timer status readback encoding
    localparam logic [1:0] ECT_ST_IDLE = 2'h0;
    localparam logic [1:0] ECT_ST_WAIT = 2'h1;
    localparam logic [1:0] ECT_ST_RUN = 2'h2;
    localparam logic [1:0] ECT_ST_DONE = 2'h3;

endpackage

// ==== ect_edge_sync.sv ====
`timescale 1ns/10ps
// Three-stage synchroniser with edge pulses, one per I/O line
module ect_edge_sync
    import ect_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_rise,
    output logic o_fall
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;

    // Stage one feeds only stage two; a change counts once two and three agree
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                lvl_r <= s3_r;
            end
        end
    end

    wire agreed = (s2_r == s3_r);
    assign o_rise = agreed & s3_r & ~lvl_r;
    assign o_fall = agreed & ~s3_r & lvl_r;

endmodule

// ==== ect_properties.sv ====
`timescale 1ns/10ps
module ect_properties
    import ect_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_count_step,
    input wire logic [3:0] i_count_clear_select,
    input wire logic [ECT_CNT_W-1:0] i_count_terminal_value,
    input wire logic i_count_clear_command,
    input wire logic i_tmr_instance_select,
    input wire logic i_tmr_enable_setting,
    input wire logic [ECT_TMR_W-1:0] i_tmr_length_us,
    input wire logic i_tmr_clear_command,
    input wire logic [ECT_CNT_W-1:0] o_count_live_value,
    input wire logic [ECT_CNT_W-1:0] o_count_captured_at_clear,
    input wire logic o_count_terminal_event,
    input wire logic o_count_running,
    input wire logic [1:0] o_tmr_state_readback,
    input wire logic [ECT_TMR_W-1:0] o_tmr_elapsed_us,
    input wire logic o_first_tmr_done_event
);
////////////////////////////////////////////////////////////////
default clocking cb @(posedge i_mclk); endclocking
default disable iff (i_rst);

a_clear_zero: assert property (i_count_clear_command |=>
    o_count_live_value == '0 && o_count_running) else $error("clear command did not zero and run");
a_clear_capture: assert property (i_count_clear_command |=>
    o_count_captured_at_clear == $past(o_count_live_value)) else $error("capture value wrong");
// Only with no clear source, so that no event clear can mask a step
a_step_count: assert property (i_count_step && o_count_running && !i_count_clear_command
    && i_count_clear_select == 4'h0 |=> o_count_live_value == $past(o_count_live_value) + 32'h1)
    else $error("live count did not step");
a_term_match: assert property (o_count_terminal_event |->
    (o_count_live_value == i_count_terminal_value) ##1 !o_count_terminal_event) else $error("terminal pulse wrong");
a_done_match: assert property (o_first_tmr_done_event |-> o_tmr_state_readback == ECT_ST_DONE
    && (o_tmr_elapsed_us == i_tmr_length_us || i_tmr_length_us == '0)) else $error("timer done early or late");
a_off_idle: assert property (!i_tmr_enable_setting |=>
    o_tmr_state_readback == ECT_ST_IDLE) else $error("disabled timer not idle");
a_tmr_clear: assert property (i_tmr_clear_command && !i_tmr_instance_select && i_tmr_enable_setting |=>
    o_tmr_elapsed_us == '0 && o_tmr_state_readback == ECT_ST_RUN) else $error("timer clear failed");
a_tick_spacing: assert property (o_tmr_elapsed_us == $past(o_tmr_elapsed_us) + 32'h1 |=>
    (o_tmr_elapsed_us != $past(o_tmr_elapsed_us) + 32'h1)[*8]) else $error("timer ticks too fast");
endmodule

bind ect_core ect_properties u_props (.*);

// ==== tb.sv ====
`timescale 1ns/10ps
module tb
    import ect_pkg::*;
;
logic i_mclk = 1'b0, i_rst = 1'b1, i_io_line_three = 1'b0, i_io_line_four = 1'b0;
logic i_tmr_instance_select = 1'b0, i_tmr_enable_setting = 1'b0;
logic [3:0] i_count_clear_select = 4'h0, i_tmr_begin_select = 4'h0;
logic [1:0] i_count_clear_edge_select = 2'h0, i_tmr_begin_edge_select = 2'h0;
logic [31:0] i_count_terminal_value = 32'hffff_ffff, i_tmr_length_us = 32'h0;
// Pulses: 0-8 events, 9 sync, 10 step, 11 begin, 12 clear, 13 timer clear
logic [13:0] pv = 14'h0;
wire i_capture_session_begin = pv[0], i_capture_session_done = pv[1];
wire i_exposure_begin_event = pv[2], i_exposure_done_event = pv[3];
wire i_sensor_readout_begin = pv[4], i_sensor_readout_done = pv[5];
wire i_profile_trigger_event = pv[6], i_accepted_profile_trigger = pv[7];
wire i_rejected_profile_trigger = pv[8], i_multi_unit_sync_signal = pv[9];
wire i_count_step = pv[10], i_count_begin_event = pv[11];
wire i_count_clear_command = pv[12], i_tmr_clear_command = pv[13];
logic [31:0] o_count_live_value, o_count_captured_at_clear, o_tmr_elapsed_us;
logic [1:0] o_tmr_state_readback;
logic o_count_terminal_event, o_count_running, o_first_tmr_done_event;
int err_total = 0, tests_run = 0, n_term = 0, n_done = 0;

always #5 i_mclk = ~i_mclk;

// Pulses are counted, since their exact cycle is the design's choice
always @(posedge i_mclk) begin
    if (o_count_terminal_event === 1'b1) n_term++;
    if (o_first_tmr_done_event === 1'b1) n_done++;
end

ect_core u_dut (.*);
////////////////////////////////////////////////////////////////
task automatic chk(logic [31:0] g, logic [31:0] e);
    tests_run++;
    if (g !== e) begin
        err_total++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
task automatic w(int n);
    repeat (n) @(posedge i_mclk);
    #1;
endtask
task automatic p(int k, int n = 1);
    @(posedge i_mclk);
    pv[k] <= 1'b1;
    repeat (n) @(posedge i_mclk);
    pv[k] <= 1'b0;
    #1;
endtask
// Line pins pass a synchroniser, so allow a few cycles
task automatic ln(int l, logic v);
    @(posedge i_mclk);
    if (l == 1) i_io_line_four <= v;
    else i_io_line_three <= v;
    w(6);
endtask
task automatic arm(logic [3:0] s, logic [1:0] e);
    @(posedge i_mclk);
    i_tmr_enable_setting <= 1'b0;
    @(posedge i_mclk);
    i_tmr_begin_select <= s;
    i_tmr_begin_edge_select <= e;
    @(posedge i_mclk);
    i_tmr_enable_setting <= 1'b1;
    w(2);
endtask
////////////////////////////////////////////////////////////////
task automatic t_cmd;
    p(12);
    p(10, 5);
    chk(o_count_live_value, 32'h5);
    // No steps arrive while the source is off, so the count holds
    w(3);
    chk(o_count_live_value, 32'h5);
    p(12);
    chk(o_count_live_value, 32'h0);
    chk(o_count_captured_at_clear, 32'h5);
    p(10);
    chk(o_count_live_value, 32'h1);
    $display("t_cmd done");
endtask
task automatic t_term;
    int n0;
    @(posedge i_mclk);
    i_count_terminal_value <= 32'h3;
    p(12);
    n0 = n_term;
    p(10, 3);
    w(2);
    chk(n_term - n0, 32'h1);
    p(10, 2);
    w(2);
    chk(n_term - n0, 32'h1);
    $display("t_term done");
endtask
task automatic t_srcs;
    for (int k = 1; k < 10; k++) begin
        @(posedge i_mclk);
        i_count_clear_select <= 4'(k);
        p(12);
        p(10, 2);
        p(k - 1);
        chk(o_count_live_value, 32'h0);
        chk(o_count_captured_at_clear, 32'h2);
        chk(o_count_running, 32'h0);
        p(10);
        chk(o_count_live_value, 32'h0);
        p(11);
        chk(o_count_running, 32'h1);
        p(10);
        chk(o_count_live_value, 32'h1);
    end
    $display("t_srcs done");
endtask
task automatic t_lines;
    for (int l = 0; l < 2; l++)
        for (int e = 0; e < 3; e++) begin
            @(posedge i_mclk);
            i_count_clear_select <= 4'ha + 4'(l);
            i_count_clear_edge_select <= 2'(e);
            p(12);
            p(10);
            ln(l, 1'b1);
            chk(o_count_live_value, (e == 1) ? 32'h1 : 32'h0);
            p(12);
            p(10);
            ln(l, 1'b0);
            chk(o_count_live_value, (e == 0) ? 32'h1 : 32'h0);
        end
    $display("t_lines done");
endtask
task automatic t_cnt1;
    @(posedge i_mclk);
    i_count_clear_select <= 4'hd;
    i_count_terminal_value <= 32'h2;
    p(12);
    p(10, 2);
    w(3);
    chk(o_count_live_value, 32'h0);
    chk(o_count_captured_at_clear, 32'h2);
    $display("t_cnt1 done");
endtask
task automatic t_tmr;
    int c, n0;
    @(posedge i_mclk);
    i_count_clear_select <= 4'hc;
    i_tmr_length_us <= 32'h2;
    arm(4'h0, 2'h0);
    chk(o_tmr_state_readback, ECT_ST_WAIT);
    p(12);
    p(10, 4);
    n0 = n_done;
    p(13);
    chk(o_tmr_state_readback, ECT_ST_RUN);
    chk(o_tmr_elapsed_us, 32'h0);
    c = 0;
    while (n_done == n0 && c < 400) begin
        w(1);
        c++;
    end
    // Two full microseconds from the start, plus the cycle in which the pulse is counted
    chk(c, 2 * ECT_TICK_CYC + 1);
    chk(o_tmr_state_readback, ECT_ST_DONE);
    chk(o_tmr_elapsed_us, 32'h2);
    chk(o_count_captured_at_clear, 32'h4);
    w(5);
    chk(n_done - n0, 32'h1);
    @(posedge i_mclk);
    i_tmr_instance_select <= 1'b1;
    p(13);
    w(1);
    chk(o_tmr_state_readback, ECT_ST_DONE);
    @(posedge i_mclk);
    i_tmr_instance_select <= 1'b0;
    i_tmr_enable_setting <= 1'b0;
    w(2);
    chk(o_tmr_state_readback, ECT_ST_IDLE);
    $display("t_tmr done");
endtask
task automatic t_tbeg;
    @(posedge i_mclk);
    i_tmr_length_us <= 32'h3e8;
    i_count_clear_select <= 4'h0;
    i_count_terminal_value <= 32'h1;
    for (int k = 1; k < 14; k++) begin
        if (k == 12) continue;
        arm(4'(k), 2'h2);
        if (k < 10) p(k == 9 ? 9 : k - 1);
        else if (k < 12) ln(k - 10, 1'b1);
        else begin
            p(12);
            p(10);
        end
        w(3);
        chk(o_tmr_state_readback, ECT_ST_RUN);
    end
    @(posedge i_mclk);
    i_tmr_enable_setting <= 1'b0;
    ln(0, 1'b0);
    ln(1, 1'b0);
    $display("t_tbeg done");
endtask
task automatic t_tline;
    for (int e = 0; e < 3; e++) begin
        arm(4'ha, 2'(e));
        ln(0, 1'b1);
        chk(o_tmr_state_readback, (e == 1) ? ECT_ST_WAIT : ECT_ST_RUN);
        arm(4'ha, 2'(e));
        ln(0, 1'b0);
        chk(o_tmr_state_readback, (e == 0) ? ECT_ST_WAIT : ECT_ST_RUN);
    end
    $display("t_tline done");
endtask
task automatic t_tchain;
    int n0;
    @(posedge i_mclk);
    i_tmr_enable_setting <= 1'b0;
    @(posedge i_mclk);
    i_tmr_length_us <= 32'h1;
    arm(4'hc, 2'h0);
    n0 = n_done;
    p(13);
    w(150);
    chk(n_done - n0, 32'h1);
    chk(o_tmr_state_readback, ECT_ST_RUN);
    chk(o_tmr_elapsed_us, 32'h0);
    w(100);
    chk(n_done - n0, 32'h2);
    @(posedge i_mclk);
    i_tmr_enable_setting <= 1'b0;
    $display("t_tchain done");
endtask
task automatic give_verdict;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////
initial begin
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    w(1);
    chk(o_tmr_state_readback, ECT_ST_IDLE);
    t_cmd;
    t_term;
    t_srcs;
    t_lines;
    t_cnt1;
    t_tmr;
    t_tbeg;
    t_tline;
    t_tchain;
    give_verdict;
end
initial begin
    repeat (20000) @(posedge i_mclk);
    err_total++;
    give_verdict;
end
endmodule
